// *** bench/core_model.sv ***
// Processor core model: issues one virtual reference at a time.
// Assumes the unit takes a request on the rising edge after it is raised.
module core_model (
  input  wire logic           i_ref_clk,
  output logic                o_valid,
  output mmu_pkg::word_t      o_va,
  output logic                o_write,
  output logic [1:0]          o_mode,
  output logic                o_dspace
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle state at time zero
  initial begin
    o_valid  = 1'b0;
    o_va     = 16'h0000;
    o_write  = 1'b0;
    o_mode   = 2'h0;
    o_dspace = 1'b0;
  end

  // Stale address is scrambled while no request stands
  always @(negedge i_ref_clk) begin
    if (!o_valid) o_va <= ~o_va;
  end

  // One reference, held until the edge that takes it
  task automatic issue(input mmu_pkg::word_t va, input logic wr, input logic [1:0] mode,
                       input logic ds);
    @(posedge i_ref_clk);
    o_valid  <= 1'b1;
    o_va     <= va;
    o_write  <= wr;
    o_mode   <= mode;
    o_dspace <= ds;
    @(posedge i_ref_clk);
    o_valid  <= 1'b0;
    #1;
  endtask
endmodule

// *** bench/tb_paged_address_relocation_protection.sv ***
// Testbench of the paged relocation unit: register tasks, reference scenarios.
// Assumes the core model drives references and registers answer one cycle later.
module tb_paged_address_relocation_protection;
  timeunit 1ns;
  timeprecision 1ps;
  logic           i_ref_clk;
  logic           i_rst;
  logic           i_clk_en;
  logic [7:0]     reg_addr;
  mmu_pkg::word_t reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  mmu_pkg::word_t o_reg_rdata;
  logic           req_valid;
  mmu_pkg::word_t req_va;
  logic           req_write;
  logic [1:0]     req_mode;
  logic           req_dspace;
  logic           o_mem_req;
  logic           o_mem_write;
  mmu_pkg::phys_t o_mem_pa;
  logic           o_abort;
  logic           o_trap;
  mmu_pkg::word_t o_fault_vector;
  int             failures;
  int             samples_checked;

  paged_address_relocation_protection uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_req_valid(req_valid), .i_req_va(req_va), .i_req_write(req_write),
    .i_req_mode(req_mode), .i_req_dspace(req_dspace), .o_mem_req(o_mem_req),
    .o_mem_write(o_mem_write), .o_mem_pa(o_mem_pa), .o_abort(o_abort), .o_trap(o_trap),
    .o_fault_vector(o_fault_vector));

  core_model core (
    .i_ref_clk(i_ref_clk), .o_valid(req_valid), .o_va(req_va), .o_write(req_write),
    .o_mode(req_mode), .o_dspace(req_dspace));

  // Clock at 50 MHz
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Closing report
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input mmu_pkg::word_t d);
    @(posedge i_ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge i_ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle register read, masked compare in the answer cycle
  task automatic rd_chk(input logic [7:0] a, input mmu_pkg::word_t m, input mmu_pkg::word_t e);
    @(posedge i_ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge i_ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(o_reg_rdata & m, e);
  endtask

  // Reference with grant/abort outcome and trap one cycle later
  task automatic xfer(input mmu_pkg::word_t va, input logic wr, input logic [1:0] mode,
                      input logic ds, input logic [1:0] ga, input logic tr);
    core.issue(va, wr, mode, ds);
    check({o_mem_req, o_abort, o_mem_write}, {ga, ga[1] & wr});
    @(posedge i_ref_clk);
    #1;
    check(o_trap, tr);
  endtask

  // Hang guard
  initial begin
    #200us;
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    i_clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check(o_fault_vector, 16'h0000);
    rd_chk(8'h80, 16'hffff, 16'h0000);
    wr_reg(8'h90, 16'h1234);
    rd_chk(8'h90, 16'hffff, 16'h0000);
    // Disabled: no relocation
    xfer(16'habcd, 1'b0, 2'h0, 1'b0, 2'b10, 1'b0);
    check(o_mem_pa, 18'h0abcd);
    // Kernel I page 6: read-only trapping key, forty blocks upward
    wr_reg(8'h46, 16'h0650);
    wr_reg(8'h06, 16'h2701);
    rd_chk(8'h06, 16'hffff, 16'h2701);
    wr_reg(8'h80, 16'h0201);
    xfer(16'hc9fe, 1'b0, 2'h0, 1'b0, 2'b10, 1'b1);
    check(o_mem_pa, 18'h19dfe);
    check(o_fault_vector, 16'h00a8);
    rd_chk(8'h06, 16'hffff, 16'h2781);
    rd_chk(8'h80, 16'hf201, 16'h1201);
    wr_reg(8'h80, 16'h0201);
    xfer(16'hca00, 1'b0, 2'h0, 1'b0, 2'b01, 1'b0);
    rd_chk(8'h80, 16'hf201, 16'h4201);
    wr_reg(8'h80, 16'h0201);
    xfer(16'hc000, 1'b1, 2'h0, 1'b0, 2'b01, 1'b0);
    rd_chk(8'h80, 16'hf201, 16'h2201);
    rd_chk(8'h06, 16'hffff, 16'h2781);
    // Trap enable off: condition only logged
    wr_reg(8'h80, 16'h0001);
    xfer(16'hc000, 1'b0, 2'h0, 1'b0, 2'b10, 1'b0);
    rd_chk(8'h80, 16'hf201, 16'h1001);
    wr_reg(8'h80, 16'h0001);
    // Kernel I page 7: downward stack page, three blocks
    wr_reg(8'h47, 16'h0100);
    wr_reg(8'h07, 16'h7d0e);
    xfer(16'hff40, 1'b1, 2'h0, 1'b0, 2'b10, 1'b0);
    check(o_mem_pa, 18'h05f40);
    xfer(16'hff3f, 1'b0, 2'h0, 1'b0, 2'b01, 1'b0);
    rd_chk(8'h07, 16'hffff, 16'h7d4e);
    wr_reg(8'h80, 16'h0001);
    // Kernel I page 5: lower base than page 6, full 128 blocks
    wr_reg(8'h45, 16'h0010);
    wr_reg(8'h05, 16'h7f06);
    xfer(16'ha012, 1'b0, 2'h0, 1'b0, 2'b10, 1'b0);
    check(o_mem_pa, 18'h00412);
    xfer(16'hbfff, 1'b0, 2'h0, 1'b0, 2'b10, 1'b0);
    check(o_mem_pa, 18'h023ff);
    // User D page 2 against an unloaded user I page 2
    wr_reg(8'h81, 16'h0001);
    wr_reg(8'h7a, 16'h0200);
    wr_reg(8'h3a, 16'h7f06);
    xfer(16'h4010, 1'b0, 2'h3, 1'b1, 2'b10, 1'b0);
    check(o_mem_pa, 18'h08010);
    xfer(16'h4010, 1'b0, 2'h3, 1'b0, 2'b01, 1'b0);
    rd_chk(8'h80, 16'hf201, 16'h8001);
    wr_reg(8'h80, 16'h0001);
    // Supervisor I page 0 never loaded: non-resident, mode logged
    xfer(16'h0000, 1'b0, 2'h1, 1'b0, 2'b01, 1'b0);
    rd_chk(8'h80, 16'h807f, 16'h8021);
    wr_reg(8'h80, 16'h0001);
    xfer(16'h4010, 1'b0, 2'h2, 1'b1, 2'b01, 1'b0);
    give_verdict();
  end
endmodule

// *** inc/mmu_map.svh ***
// Constants of the paged relocation and protection unit: offsets, fields, keys, codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MMU_MAP_SVH
`define MMU_MAP_SVH

// Register port addressing
`define REG_AW        8
`define RA_PAGE_BIT   7
`define RA_BASE_BIT   6
`define RA_MODE_HI    5
`define RA_MODE_LO    4
`define RA_LOW_HI     3
`define RA_STATUS     8'h80
`define RA_DSPACE     8'h81

// Storage shape: three modes, two spaces, eight pages
`define SLOT_W        6
`define SLOTS         48

// Descriptor fields
`define PD_LEN_HI     14
`define PD_LEN_LO     8
`define PD_ACC        7
`define PD_WR         6
`define PD_ED         3
`define PD_KEY_HI     2
`define PD_KEY_LO     0
`define PD_WMASK      16'h7fcf
`define PD_RESET      16'h0000
`define PB_RESET      12'h000

// Main status fields
`define ST_NONRES     15
`define ST_LEN        14
`define ST_RO         13
`define ST_TRAP       12
`define ST_TRAP_EN    9
`define ST_MAINT      8
`define ST_MODE_HI    6
`define ST_MODE_LO    5
`define ST_SPACE      4
`define ST_PAGE_HI    3
`define ST_PAGE_LO    1
`define ST_ENABLE     0
`define ST_WMASK      16'hf301
`define ST_RESET      16'h0000
`define DSP_RESET     3'h0
`define DSP_USER      0
`define DSP_SUP       1
`define DSP_KERN      2

// Access control keys
`define KEY_RO_TRAP   3'h1
`define KEY_RO        3'h2
`define KEY_RW_TRAP   3'h4
`define KEY_RW_TRAPW  3'h5
`define KEY_ABS0      3'h0
`define KEY_ABS3      3'h3
`define KEY_ABS7      3'h7

// Processor modes
`define MODE_KERNEL   2'h0
`define MODE_SUP      2'h1
`define MODE_BAD      2'h2
`define MODE_USER     2'h3

// Virtual address fields and relocation
`define VA_PAGE_HI    15
`define VA_PAGE_LO    13
`define VA_BLK_HI     12
`define VA_BLK_LO     6
`define VA_OFF_HI     12
`define BLOCK_SHIFT   6
`define PA_W          18
`define FAULT_VECTOR  16'h00a8

`endif

// *** inc/mmu_pkg.sv ***
// Types shared by the relocation unit and its page check.
// Assumes the constant header is on the include path.
`include "mmu_map.svh"
package mmu_pkg;
  typedef logic [15:0]          word_t;
  typedef logic [`PA_W-1:0]     phys_t;
  typedef logic [6:0]           block_t;
  typedef logic [2:0]           key_t;
  typedef logic [`SLOT_W-1:0]   slot_t;
endpackage

// *** logic/page_check.sv ***
// Page check: judges one reference against one page descriptor.
// Assumes the caller applies the enable bit and the mode check itself.
`include "mmu_map.svh"
module page_check (
  input  wire logic           i_write,
  input  wire mmu_pkg::word_t  i_desc,
  input  wire mmu_pkg::block_t i_block,
  output logic                o_key_absent,
  output logic                o_len_err,
  output logic                o_ro_err,
  output logic                o_trap_cond
);
  // Descriptor fields
  wire mmu_pkg::key_t   key       = i_desc[`PD_KEY_HI:`PD_KEY_LO];
  wire mmu_pkg::block_t limit     = i_desc[`PD_LEN_HI:`PD_LEN_LO];
  wire                  expand_dn = i_desc[`PD_ED];
  // Page length test in either expansion direction
  assign o_len_err = expand_dn ? (i_block < limit)  // see [RQ11] see [RQ12]
                               : (i_block > limit); // see [RQ5] see [RQ10]
  // Key decoding
  assign o_key_absent = (key == `KEY_ABS0) | (key == `KEY_ABS3) | (key == `KEY_ABS7);
  assign o_ro_err     = i_write & ((key == `KEY_RO_TRAP) | (key == `KEY_RO)); // see [RQ8]
  assign o_trap_cond  = i_write ? ((key == `KEY_RW_TRAP) | (key == `KEY_RW_TRAPW))
                                : ((key == `KEY_RO_TRAP) | (key == `KEY_RW_TRAP)); // see [RQ9]
endmodule

// *** logic/paged_address_relocation_protection.sv ***
// Paged relocation and protection unit: page registers, translation, aborts, traps.
// Assumes a core that holds i_req_* for one cycle per reference, synchronous to i_ref_clk.
//
// Overview of operation
// [RQ1] Eight I and D page pairs per mode
// [RQ2] A page spans one to 128 blocks
// [RQ3] Top three address bits select the page
// [RQ4] Page start is base times 64 bytes
// [RQ5] Upward page beyond length field aborts
// [RQ6] Key violation or trapped reference sets accessed
// [RQ7] Written flag records any page modification
// [RQ8] Write to read-only page aborts
// [RQ9] Trapping read completes, then trap follows
// [RQ10] Clear direction flag grows page upward
// [RQ11] Set direction flag grows page downward
// [RQ12] Downward page below length field aborts
// [RQ13] Software loads page registers before use
// [RQ14] Every page base is independent
// [RQ15] Block index is address bits 12..6
// [RQ16] Enable bit zero passes addresses through
// [RQ17] Length abort sets status bit 14
// [RQ18] Real trap only when trap enable set
// [RQ19] Physical address is shifted base plus offset
// [RQ20] Aborted references make no memory cycle
//
// Chosen here: the plain strobed port and the register offsets.
`include "mmu_map.svh"
module paged_address_relocation_protection #(
  parameter int BASE_W = 12
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_clk_en,
  input  wire logic [`REG_AW-1:0]      i_reg_addr,
  input  wire mmu_pkg::word_t          i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output mmu_pkg::word_t               o_reg_rdata,
  input  wire logic                    i_req_valid,
  input  wire mmu_pkg::word_t          i_req_va,
  input  wire logic                    i_req_write,
  input  wire logic [1:0]              i_req_mode,
  input  wire logic                    i_req_dspace,
  output logic                         o_mem_req,
  output logic                         o_mem_write,
  output mmu_pkg::phys_t               o_mem_pa,
  output logic                         o_abort,
  output logic                         o_trap,
  output mmu_pkg::word_t               o_fault_vector
);

  // Mode code to storage group: kernel, supervisor, user
  function automatic logic [1:0] mode_group(input logic [1:0] m);
    case (m)
      `MODE_KERNEL: mode_group = 2'h0;
      `MODE_SUP:    mode_group = 2'h1;
      default:      mode_group = 2'h2;
    endcase
  endfunction

  // Descriptor after a software write and hardware flag logging
  function automatic mmu_pkg::word_t desc_update(input mmu_pkg::word_t old_val,
                                                 input logic wr, input mmu_pkg::word_t wdata,
                                                 input logic set_a, input logic set_w);
    mmu_pkg::word_t v;
    v = wr ? (wdata & `PD_WMASK) : old_val;
    v[`PD_ACC] = v[`PD_ACC] | set_a;
    v[`PD_WR]  = v[`PD_WR] | set_w;
    desc_update = v;
  endfunction

  // Page register storage, one slot per mode, space and page
  mmu_pkg::word_t    desc_reg [0:`SLOTS-1]; // see [RQ1]
  logic [BASE_W-1:0] base_reg [0:`SLOTS-1];
  mmu_pkg::word_t    status_reg;
  mmu_pkg::word_t    status_next;
  logic [2:0]        dsp_reg;
  mmu_pkg::word_t    rdata_reg;
  logic              mem_req_reg;
  logic              mem_write_reg;
  mmu_pkg::phys_t    mem_pa_reg;
  logic              abort_reg;
  logic              trap_pend_reg;
  logic              trap_reg;
  mmu_pkg::word_t    vector_reg;

  // Register port decode
  wire [1:0]        reg_mode    = i_reg_addr[`RA_MODE_HI:`RA_MODE_LO];
  wire              reg_page    = ~i_reg_addr[`RA_PAGE_BIT] & (reg_mode != `MODE_BAD);
  wire              reg_is_base = i_reg_addr[`RA_BASE_BIT];
  wire mmu_pkg::slot_t reg_slot = {mode_group(reg_mode), i_reg_addr[`RA_LOW_HI:0]};
  wire              desc_wr     = i_reg_wr & reg_page & ~reg_is_base;
  wire              base_wr     = i_reg_wr & reg_page & reg_is_base;
  wire              status_wr   = i_reg_wr & (i_reg_addr == `RA_STATUS);
  wire              dsp_wr      = i_reg_wr & (i_reg_addr == `RA_DSPACE);

  // Read data selection, unmapped addresses read zero
  wire mmu_pkg::word_t page_rd  = reg_is_base ? {{(16-BASE_W){1'b0}}, base_reg[reg_slot]}
                                              : desc_reg[reg_slot];
  wire mmu_pkg::word_t rd_value = reg_page                     ? page_rd :
                                  (i_reg_addr == `RA_STATUS)   ? status_reg :
                                  (i_reg_addr == `RA_DSPACE)   ? {13'h0000, dsp_reg} :
                                  16'h0000;

  // Request side page selection
  wire [1:0]        req_group = mode_group(i_req_mode);
  wire              dsp_on    = (req_group == 2'h0) ? dsp_reg[`DSP_KERN] :
                                (req_group == 2'h1) ? dsp_reg[`DSP_SUP] : dsp_reg[`DSP_USER];
  wire              req_dsel  = i_req_dspace & dsp_on;
  wire [2:0]        req_page  = i_req_va[`VA_PAGE_HI:`VA_PAGE_LO]; // see [RQ3]
  wire mmu_pkg::slot_t req_slot = {req_group, req_dsel, req_page}; // see [RQ1]
  wire mmu_pkg::word_t req_desc = desc_reg[req_slot];
  wire mmu_pkg::block_t req_blk = i_req_va[`VA_BLK_HI:`VA_BLK_LO]; // see [RQ15]
  wire [BASE_W-1:0] req_base  = base_reg[req_slot]; // see [RQ14]

  // Per-page judgement
  logic key_absent;
  logic len_err;
  logic ro_err;
  logic trap_cond;
  page_check u_page_check (
    .i_write      (i_req_write),
    .i_desc       (req_desc),
    .i_block      (req_blk),
    .o_key_absent (key_absent),
    .o_len_err    (len_err),
    .o_ro_err     (ro_err),
    .o_trap_cond  (trap_cond)
  );

  // Fault classification, only while relocating
  wire reloc     = status_reg[`ST_ENABLE]; // see [RQ16]
  wire mode_bad  = i_req_mode == `MODE_BAD;
  wire take      = i_clk_en & i_req_valid;
  wire f_nonres  = reloc & (mode_bad | key_absent);
  wire f_len     = reloc & ~mode_bad & len_err; // see [RQ5] see [RQ12]
  wire f_ro      = reloc & ~mode_bad & ~key_absent & ro_err; // see [RQ8]
  wire aborted   = f_nonres | f_len | f_ro;
  wire f_trap    = reloc & ~aborted & trap_cond;
  wire trap_fire = take & f_trap & status_reg[`ST_TRAP_EN]; // see [RQ18]
  wire key_viol  = reloc & ~mode_bad & (key_absent | ro_err);
  wire set_acc   = take & (key_viol | f_trap); // see [RQ6]
  wire set_wr    = take & reloc & ~aborted & i_req_write; // see [RQ7]
  wire frozen    = |status_reg[`ST_NONRES:`ST_RO];

  // Address formation: base in 64-byte blocks plus in-page offset
  wire mmu_pkg::phys_t base_pa  = {base_reg[req_slot], {`BLOCK_SHIFT{1'b0}}}; // see [RQ4]
  wire mmu_pkg::phys_t off_pa   = {{(`PA_W-`VA_OFF_HI-1){1'b0}}, i_req_va[`VA_OFF_HI:0]};
  wire mmu_pkg::phys_t reloc_pa = base_pa + off_pa; // see [RQ19] see [RQ2]
  wire mmu_pkg::phys_t next_pa  = reloc ? reloc_pa
                                        : {{(`PA_W-16){1'b0}}, i_req_va}; // see [RQ16]

  // Main status next value; hardware events win over a software clear
  always_comb begin
    status_next = status_reg;
    if (status_wr) begin
      status_next = (status_reg & ~`ST_WMASK) | (i_reg_wdata & `ST_WMASK);
    end
    if (take) begin
      status_next[`ST_NONRES] = status_next[`ST_NONRES] | f_nonres;
      status_next[`ST_LEN]    = status_next[`ST_LEN] | f_len; // see [RQ17]
      status_next[`ST_RO]     = status_next[`ST_RO] | f_ro;
      status_next[`ST_TRAP]   = status_next[`ST_TRAP] | f_trap;
    end
    if (take && !frozen && (aborted || f_trap)) begin
      status_next[`ST_MODE_HI:`ST_MODE_LO] = i_req_mode;
      status_next[`ST_SPACE]               = req_dsel;
      status_next[`ST_PAGE_HI:`ST_PAGE_LO] = req_page;
    end
  end

  // Descriptor storage with flag logging
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `SLOTS; i++) begin
        desc_reg[i] <= `PD_RESET;
      end
    end else if (i_clk_en) begin
      for (int i = 0; i < `SLOTS; i++) begin
        desc_reg[i] <= desc_update(desc_reg[i], desc_wr && (reg_slot == 6'(i)), i_reg_wdata,
                                   set_acc && (req_slot == 6'(i)),
                                   set_wr && (req_slot == 6'(i))); // see [RQ6] see [RQ7]
      end
    end
  end

  // Base storage, any value per page
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `SLOTS; i++) begin
        base_reg[i] <= `PB_RESET;
      end
    end else if (i_clk_en && base_wr) begin
      base_reg[reg_slot] <= i_reg_wdata[BASE_W-1:0]; // see [RQ14]
    end
  end

  // Status, space enable and read data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= `ST_RESET;
      dsp_reg    <= `DSP_RESET;
      rdata_reg  <= 16'h0000;
    end else if (i_clk_en) begin
      status_reg <= status_next;
      if (dsp_wr) begin
        dsp_reg <= i_reg_wdata[2:0];
      end
      rdata_reg <= i_reg_rd ? rd_value : 16'h0000;
    end
  end

  // Memory cycle and fault outputs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_req_reg   <= 1'b0;
      mem_write_reg <= 1'b0;
      mem_pa_reg    <= '0;
      abort_reg     <= 1'b0;
      trap_pend_reg <= 1'b0;
      trap_reg      <= 1'b0;
      vector_reg    <= 16'h0000;
    end else if (i_clk_en) begin
      mem_req_reg   <= take & ~aborted; // see [RQ20]
      mem_write_reg <= take & ~aborted & i_req_write;
      abort_reg     <= take & aborted;
      trap_pend_reg <= trap_fire;
      trap_reg      <= trap_pend_reg; // see [RQ9]
      if (take) begin
        mem_pa_reg <= next_pa;
      end
      if ((take && aborted) || trap_fire) begin
        vector_reg <= `FAULT_VECTOR;
      end
    end
  end

  assign o_reg_rdata    = rdata_reg;
  assign o_mem_req      = mem_req_reg;
  assign o_mem_write    = mem_write_reg;
  assign o_mem_pa       = mem_pa_reg;
  assign o_abort        = abort_reg;
  assign o_trap         = trap_reg;
  assign o_fault_vector = vector_reg;

  // Checks on the translation and protection behaviour
  chk_abort_no_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ20]
    o_abort |-> !o_mem_req && !o_mem_write)
    else $error("aborted reference produced a memory cycle");

  chk_len_up_abort: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ5]
    take && reloc && !mode_bad && !req_desc[`PD_ED] && (req_blk > req_desc[`PD_LEN_HI:`PD_LEN_LO])
    |=> o_abort && status_reg[`ST_LEN] && o_fault_vector == `FAULT_VECTOR)
    else $error("upward page overrun not aborted");

  chk_len_down_abort: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ12]
    take && reloc && !mode_bad && req_desc[`PD_ED] && (req_blk < req_desc[`PD_LEN_HI:`PD_LEN_LO])
    |=> o_abort && status_reg[`ST_LEN])
    else $error("downward page underrun not aborted");

  chk_down_in_range: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ11]
    take && reloc && !mode_bad && req_desc[`PD_ED] && !key_absent && !ro_err &&
    (req_blk >= req_desc[`PD_LEN_HI:`PD_LEN_LO]) |=> o_mem_req)
    else $error("downward page reference inside range refused");

  chk_ro_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ8]
    take && reloc && !mode_bad && i_req_write &&
    (req_desc[`PD_KEY_HI:`PD_KEY_LO] == `KEY_RO) |=> o_abort && status_reg[`ST_RO])
    else $error("write to read-only page not aborted");

  chk_trap_after: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ9]
    (trap_fire && !i_req_write ##1 i_clk_en) |-> o_mem_req && !o_trap ##1 o_trap)
    else $error("read trap not after completed read");

  chk_trap_gated: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ18]
    take && f_trap && !status_reg[`ST_TRAP_EN] && !trap_pend_reg |=> ##1 !o_trap)
    else $error("trap raised while traps disabled");

  chk_pass_through: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ16]
    take && !reloc |=> o_mem_req && !o_abort && o_mem_pa == {2'b00, $past(i_req_va)})
    else $error("disabled unit altered or refused an address");

  chk_pa_form: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ19]
    take && reloc && !aborted
    |=> o_mem_pa == ({$past(req_base), 6'h00} + {5'h00, $past(i_req_va[`VA_OFF_HI:0])}))
    else $error("physical address not base times 64 plus offset");

  chk_written_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ7]
    set_wr |=> desc_reg[$past(req_slot)][`PD_WR])
    else $error("written flag not set after page write");

  chk_access_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ6]
    take && key_viol |=> desc_reg[$past(req_slot)][`PD_ACC])
    else $error("accessed flag not set on key violation");

  // Outcome, selection and trap checks
  chk_one_outcome: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ20]
    take
    |=> o_mem_req != o_abort)
    else $error("reference gave neither or both of grant and abort");

  chk_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ20]
    i_clk_en && !i_req_valid
    |=> !o_mem_req && !o_abort)
    else $error("memory cycle or abort without a reference");

  chk_nonres_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ6]
    take && reloc && !mode_bad && key_absent
    |=> o_abort && desc_reg[$past(req_slot)][`PD_ACC])
    else $error("absent key not aborted or not logged");

  chk_bad_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ20]
    take && reloc && mode_bad
    |=> o_abort && !o_mem_req && status_reg[`ST_NONRES])
    else $error("illegal mode reference not aborted");

  chk_up_in_range: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ10]
    take && reloc && !mode_bad && !req_desc[`PD_ED] && !key_absent && !ro_err &&
    (req_blk <= req_desc[`PD_LEN_HI:`PD_LEN_LO]) |=> o_mem_req)
    else $error("upward page reference inside range refused");

  chk_trap_vector: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ18]
    take && f_trap && status_reg[`ST_TRAP_EN]
    |=> o_fault_vector == `FAULT_VECTOR)
    else $error("enabled trap left the fault vector unset");

  chk_trap_logged: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ18]
    take && f_trap
    |=> status_reg[`ST_TRAP])
    else $error("trap condition not logged in status");

  chk_off_no_trap: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ16]
    take && !reloc
    |=> ##1 !o_trap)
    else $error("trap raised while relocation disabled");

  chk_base_origin: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ4]
    take && reloc && !aborted && (i_req_va[`VA_OFF_HI:0] == '0)
    |=> o_mem_pa == {$past(req_base), {`BLOCK_SHIFT{1'b0}}})
    else $error("page origin not base times 64");

  chk_space_select: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ1]
    take && !i_req_dspace
    |-> !req_dsel)
    else $error("instruction reference used data registers");

  chk_page_index: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see [RQ3]
    take
    |-> req_page == i_req_va[`VA_PAGE_HI:`VA_PAGE_LO])
    else $error("page index not taken from top address bits");

endmodule
